// ---- core/half_duplex_slave_serial_link.sv ----
// Half-duplex slave link controller with APB registers and one level interrupt.
// Assumes a polling master on the line and a program that queues messages.
//
// Contract
// R1: Bit rates 300 to 38400 baud selectable; parity none or even.
// R2: Line control: plain, half-duplex modem with RTS/CTS, or shared RS-485.
// R3: With end-of-transmission suppression, an empty queue answers a poll with nothing.
// R4: With duplicate detection, a repeated packet is dropped, not acted on twice.
// R5: Own message waits poll-timeout in 20 ms units; expiry flags message error.
// R6: Poll-timeout of zero disables the timeout completely.
// R7: Software should set a nonzero poll-timeout when sending own messages.
// R8: After poll-timeout error, software requeues; hardware never retries it.
// R9: Modem mode holds RTS for the off-delay, 20 ms units, after last character.
// R10: Modem mode waits send delay, 20 ms units, after RTS before checking CTS.
// R11: Unacknowledged packet is resent up to the retry count, 0 to 255.
// R12: Without handshaking, wait pre-transmit delay in 1 ms units before sending.
// R13: Modem mode leaves pre-transmit delay between last received character and RTS.
// R14: Token-passing protocol must never be run over modems on this port.
// R15: Over modems, master/slave protocol reaches several controllers.
// R16: Master acknowledges each good slave packet and polls each slave.
// R17: Retries exhausted: stop sending and report a message error.
//
// Decided for this implementation: the register offsets and the APB slave port.
`default_nettype none

module half_duplex_slave_serial_link #(
  parameter int unsigned MS_CYCLES = serial_link_pkg::MS_CYCLES_DEF
) (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial line
  input  wire logic        rxd,
  output logic             txd,
  output logic             rts,
  input  wire logic        cts,
  output logic             drv_en,
  // Interrupt
  output logic             irq
);

  if (MS_CYCLES < 2) begin : g_bad_ms
    $error("MS_CYCLES too small");
  end

  serial_link_pkg::cfg_t        cfg;
  serial_link_pkg::link_state_t state_ff;
  serial_link_pkg::reply_t      req_kind_ff;
  serial_link_pkg::reply_t      kind_ff;

  logic [31:0]   ms_cnt_ff;
  logic [4:0]    sl_cnt_ff;
  logic          ms_tick_ff;
  logic          slow_tick_ff;
  logic [7:0]    ctrl_ff;
  logic [15:0]   poll_to_ff;
  logic [15:0]   rts_off_ff;
  logic [15:0]   rts_send_ff;
  logic [7:0]    retries_ff;
  logic [15:0]   pre_tx_ff;
  logic [serial_link_pkg::ST_W-1:0] status_ff;
  logic [serial_link_pkg::ST_W-1:0] mask_ff;
  logic [serial_link_pkg::ST_W-1:0] st_set;
  logic [31:0]   rd_mux;
  logic          rd_hit;
  logic          wr_acc;
  logic          rd_acc;
  logic          pend_ff;
  logic [7:0]    tx_payload_ff;
  logic [7:0]    tx_seq_ff;
  logic [16:0]   pt_cnt_ff;
  logic          pt_fire;
  logic [1:0]    rx_idx_ff;
  logic [7:0]    rx_seq_tmp_ff;
  logic [7:0]    rx_seq_ff;
  logic [7:0]    rx_payload_ff;
  logic          seen_ff;
  logic          poll_evt_ff;
  logic          ack_evt_ff;
  logic          data_evt_ff;
  logic          dup_evt_ff;
  logic          req_ff;
  logic [16:0]   dly_cnt_ff;
  logic [1:0]    byte_idx_ff;
  logic [7:0]    try_ff;
  logic          tx_start_ff;
  logic [7:0]    tx_byte_ff;
  logic          done_ok_ff;
  logic          done_err_ff;
  logic [15:0]   lim;
  logic          wait_done;
  logic          tick;
  logic [1:0]    n_bytes;
  logic [7:0]    byte_mux;
  logic          rx_ok;
  logic          tx_busy;
  logic          rx_valid;
  logic          rx_perr;
  logic [7:0]    rx_byte;

  assign cfg = serial_link_pkg::cfg_t'(ctrl_ff);

  // Byte engine at the selected rate and parity
  serial_byte_phy #(.BIT_W(serial_link_pkg::BIT_W)) u_phy (
    .clk        (clk),
    .rst        (rst),
    .ce         (ce),
    .bit_cycles (serial_link_pkg::baud_div(cfg.baud)),  // R1
    .par_even   (cfg.par_even),                          // R1
    .tx_start   (tx_start_ff),
    .tx_byte    (tx_byte_ff),
    .tx_busy    (tx_busy),
    .txd        (txd),
    .rxd        (rxd),
    .rx_valid   (rx_valid),
    .rx_byte    (rx_byte),
    .rx_perr    (rx_perr)
  );

  // 1 ms and 20 ms time bases
  always_ff @(posedge clk) begin
    if (rst) begin
      ms_cnt_ff    <= '0;
      sl_cnt_ff    <= '0;
      ms_tick_ff   <= 1'b0;
      slow_tick_ff <= 1'b0;
    end else if (ce) begin
      ms_tick_ff   <= (ms_cnt_ff == 32'(MS_CYCLES - 1));
      ms_cnt_ff    <= (ms_cnt_ff == 32'(MS_CYCLES - 1)) ? '0 : ms_cnt_ff + 32'h1;
      slow_tick_ff <= 1'b0;
      if (ms_tick_ff) begin
        slow_tick_ff <= (sl_cnt_ff == 5'(serial_link_pkg::SLOW_TICK_MS - 1));
        sl_cnt_ff    <= (sl_cnt_ff == 5'(serial_link_pkg::SLOW_TICK_MS - 1)) ? '0
                        : sl_cnt_ff + 5'h1;
      end
    end
  end

  // APB access decode, answer ready in the first access cycle
  assign wr_acc = psel & penable & pready & pwrite;
  assign rd_acc = psel & penable & pready & ~pwrite;

  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case (paddr)
      serial_link_pkg::OFF_CTRL:     rd_mux = 32'(ctrl_ff);
      serial_link_pkg::OFF_POLL_TO:  rd_mux = 32'(poll_to_ff);
      serial_link_pkg::OFF_RTS_OFF:  rd_mux = 32'(rts_off_ff);
      serial_link_pkg::OFF_RTS_SEND: rd_mux = 32'(rts_send_ff);
      serial_link_pkg::OFF_RETRIES:  rd_mux = 32'(retries_ff);
      serial_link_pkg::OFF_PRE_TX:   rd_mux = 32'(pre_tx_ff);
      serial_link_pkg::OFF_TX_QUEUE: rd_mux = 32'({tx_seq_ff, tx_payload_ff});
      serial_link_pkg::OFF_RX_DATA:  rd_mux = 32'({rx_seq_ff, rx_payload_ff});
      serial_link_pkg::OFF_STATUS:   rd_mux = 32'(status_ff);
      serial_link_pkg::OFF_MASK:     rd_mux = 32'(mask_ff);
      serial_link_pkg::OFF_STATE:    rd_mux = 32'({try_ff, 6'h00, state_ff != serial_link_pkg::S_IDLE, pend_ff});
      default:                       rd_hit = 1'b0;
    endcase
  end

  // Bus answer registers
  always_ff @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= psel & ~penable & ~pready;
      if (psel & ~penable) begin
        prdata  <= pwrite ? '0 : rd_mux;
        pslverr <= ~rd_hit | (pwrite & pend_ff & (paddr == serial_link_pkg::OFF_TX_QUEUE));
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff     <= serial_link_pkg::CTRL_RST;
      poll_to_ff  <= '0;
      rts_off_ff  <= '0;
      rts_send_ff <= '0;
      retries_ff  <= serial_link_pkg::RETRY_RST;
      pre_tx_ff   <= '0;
      mask_ff     <= '0;
    end else if (ce && wr_acc) begin
      case (paddr)
        serial_link_pkg::OFF_CTRL:     ctrl_ff     <= pwdata[7:0];
        serial_link_pkg::OFF_POLL_TO:  poll_to_ff  <= pwdata[15:0];
        serial_link_pkg::OFF_RTS_OFF:  rts_off_ff  <= pwdata[15:0];
        serial_link_pkg::OFF_RTS_SEND: rts_send_ff <= pwdata[15:0];
        serial_link_pkg::OFF_RETRIES:  retries_ff  <= pwdata[7:0];
        serial_link_pkg::OFF_PRE_TX:   pre_tx_ff   <= pwdata[15:0];
        serial_link_pkg::OFF_MASK:     mask_ff     <= pwdata[serial_link_pkg::ST_W-1:0];
        default: ;
      endcase
    end
  end

  // Sticky status, read clears only what was returned, set wins
  always_comb begin
    st_set = '0;
    st_set[serial_link_pkg::ST_RX_PKT] = data_evt_ff & ~dup_evt_ff;
    st_set[serial_link_pkg::ST_TX_ACK] = done_ok_ff;
    st_set[serial_link_pkg::ST_POLL]   = pt_fire;      // R5
    st_set[serial_link_pkg::ST_RETRY]  = done_err_ff;  // R17
    st_set[serial_link_pkg::ST_DUP]    = dup_evt_ff;
    st_set[serial_link_pkg::ST_PERR]   = rx_valid & rx_perr;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status_ff <= '0;
      irq       <= 1'b0;
    end else if (ce) begin
      status_ff <= (status_ff & ~((rd_acc && paddr == serial_link_pkg::OFF_STATUS)
                   ? prdata[serial_link_pkg::ST_W-1:0] : '0)) | st_set;
      irq       <= |(status_ff & mask_ff);
    end
  end

  // Own message slot and poll timeout; errors drop it for software to requeue
  assign pt_fire = pend_ff && (poll_to_ff != '0) && (pt_cnt_ff > {1'b0, poll_to_ff})
                   && (state_ff == serial_link_pkg::S_IDLE);  // R5 R6 R8

  always_ff @(posedge clk) begin
    if (rst) begin
      pend_ff       <= 1'b0;
      tx_payload_ff <= '0;
      tx_seq_ff     <= '0;
      pt_cnt_ff     <= '0;
    end else if (ce) begin
      if (poll_evt_ff || !pend_ff || state_ff != serial_link_pkg::S_IDLE) pt_cnt_ff <= '0;  // R5
      else if (slow_tick_ff && pt_cnt_ff <= {1'b0, poll_to_ff}) pt_cnt_ff <= pt_cnt_ff + 17'h1;
      if (wr_acc && paddr == serial_link_pkg::OFF_TX_QUEUE && !pend_ff) begin
        pend_ff       <= 1'b1;
        tx_payload_ff <= pwdata[7:0];
        tx_seq_ff     <= tx_seq_ff + 8'h1;
      end else if (done_ok_ff || done_err_ff || pt_fire) begin
        pend_ff <= 1'b0;  // R8 R17
      end
    end
  end

  // Received byte parser; own echo ignored while sending
  assign rx_ok = rx_valid & ~rx_perr & (state_ff != serial_link_pkg::S_SEND);

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_idx_ff     <= '0;
      rx_seq_tmp_ff <= '0;
      rx_seq_ff     <= '0;
      rx_payload_ff <= '0;
      seen_ff       <= 1'b0;
      poll_evt_ff   <= 1'b0;
      ack_evt_ff    <= 1'b0;
      data_evt_ff   <= 1'b0;
      dup_evt_ff    <= 1'b0;
    end else if (ce) begin
      poll_evt_ff <= 1'b0;
      ack_evt_ff  <= 1'b0;
      data_evt_ff <= 1'b0;
      dup_evt_ff  <= 1'b0;
      if (rx_ok) begin
        unique case (rx_idx_ff)
          2'h0: begin
            poll_evt_ff <= (rx_byte == serial_link_pkg::CODE_POLL);
            ack_evt_ff  <= (rx_byte == serial_link_pkg::CODE_ACK);
            if (rx_byte == serial_link_pkg::CODE_DATA) rx_idx_ff <= 2'h1;
          end
          2'h1: begin
            rx_seq_tmp_ff <= rx_byte;
            rx_idx_ff     <= 2'h2;
          end
          default: begin
            rx_idx_ff   <= 2'h0;
            data_evt_ff <= 1'b1;
            if (cfg.dup_en && seen_ff && rx_seq_tmp_ff == rx_seq_ff) begin
              dup_evt_ff <= 1'b1;  // R4
            end else begin
              rx_seq_ff     <= rx_seq_tmp_ff;
              rx_payload_ff <= rx_byte;
              seen_ff       <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // Reply request: ACK for data, message or EOT for a poll
  always_ff @(posedge clk) begin
    if (rst) begin
      req_ff      <= 1'b0;
      req_kind_ff <= serial_link_pkg::RP_EOT;
    end else if (ce) begin
      if (req_ff) begin
        if (state_ff == serial_link_pkg::S_IDLE) req_ff <= 1'b0;
      end else if (state_ff == serial_link_pkg::S_IDLE) begin
        if (data_evt_ff) begin
          req_ff      <= 1'b1;
          req_kind_ff <= serial_link_pkg::RP_ACK;
        end else if (poll_evt_ff && pend_ff) begin
          req_ff      <= 1'b1;
          req_kind_ff <= serial_link_pkg::RP_DATA;
        end else if (poll_evt_ff && !cfg.eot_sup) begin  // R3
          req_ff      <= 1'b1;
          req_kind_ff <= serial_link_pkg::RP_EOT;
        end
      end
    end
  end

  // Delay limit for the current state; done once more than lim units passed
  always_comb begin
    case (state_ff)
      serial_link_pkg::S_TURN:     lim = pre_tx_ff;    // R12 R13
      serial_link_pkg::S_RTS_LEAD: lim = rts_send_ff;  // R10
      serial_link_pkg::S_RTS_HOLD: lim = rts_off_ff;   // R9
      serial_link_pkg::S_WAIT_ACK: lim = 16'(serial_link_pkg::ACK_TO_SLOW);
      default:                     lim = '0;
    endcase
    wait_done = (lim == '0) || (dly_cnt_ff > {1'b0, lim});
    tick      = (state_ff == serial_link_pkg::S_TURN) ? ms_tick_ff : slow_tick_ff;
    n_bytes   = (kind_ff == serial_link_pkg::RP_DATA) ? 2'h3 : 2'h1;
    unique case (byte_idx_ff)
      2'h0:    byte_mux = (kind_ff == serial_link_pkg::RP_DATA) ? serial_link_pkg::CODE_DATA
                        : (kind_ff == serial_link_pkg::RP_ACK) ? serial_link_pkg::CODE_ACK
                        : serial_link_pkg::CODE_EOT;
      2'h1:    byte_mux = tx_seq_ff;
      default: byte_mux = tx_payload_ff;
    endcase
  end

  // Transmit sequencer: turnaround, modem handshake, bytes, acknowledge wait
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff    <= serial_link_pkg::S_IDLE;
      kind_ff     <= serial_link_pkg::RP_EOT;
      dly_cnt_ff  <= '0;
      byte_idx_ff <= '0;
      try_ff      <= '0;
      rts         <= 1'b0;
      drv_en      <= 1'b0;
      tx_start_ff <= 1'b0;
      tx_byte_ff  <= '0;
      done_ok_ff  <= 1'b0;
      done_err_ff <= 1'b0;
    end else if (ce) begin
      tx_start_ff <= 1'b0;
      done_ok_ff  <= 1'b0;
      done_err_ff <= 1'b0;
      if (tick && !wait_done) dly_cnt_ff <= dly_cnt_ff + 17'h1;
      unique case (state_ff)
        serial_link_pkg::S_IDLE: if (req_ff) begin
          kind_ff    <= req_kind_ff;
          dly_cnt_ff <= '0;
          state_ff   <= serial_link_pkg::S_TURN;
          if (req_kind_ff == serial_link_pkg::RP_DATA) try_ff <= '0;
        end
        serial_link_pkg::S_TURN: if (wait_done) begin  // R12 R13
          dly_cnt_ff  <= '0;
          byte_idx_ff <= '0;
          if (cfg.mode == serial_link_pkg::LINE_MODEM) begin  // R2 R15
            rts      <= 1'b1;
            state_ff <= serial_link_pkg::S_RTS_LEAD;
          end else begin
            drv_en   <= (cfg.mode == serial_link_pkg::LINE_RS485);  // R2
            state_ff <= serial_link_pkg::S_SEND;
          end
        end
        serial_link_pkg::S_RTS_LEAD: if (wait_done) state_ff <= serial_link_pkg::S_CTS;  // R10
        serial_link_pkg::S_CTS: if (cts) state_ff <= serial_link_pkg::S_SEND;
        serial_link_pkg::S_SEND: if (!tx_start_ff && !tx_busy) begin
          if (byte_idx_ff != n_bytes) begin
            tx_start_ff <= 1'b1;
            tx_byte_ff  <= byte_mux;
            byte_idx_ff <= byte_idx_ff + 2'h1;
          end else if (rts) begin
            dly_cnt_ff <= '0;
            state_ff   <= serial_link_pkg::S_RTS_HOLD;  // R9
          end else begin
            drv_en     <= 1'b0;
            dly_cnt_ff <= '0;
            state_ff   <= (kind_ff == serial_link_pkg::RP_DATA) ? serial_link_pkg::S_WAIT_ACK
                          : serial_link_pkg::S_IDLE;
          end
        end
        serial_link_pkg::S_RTS_HOLD: if (wait_done) begin  // R9
          rts        <= 1'b0;
          dly_cnt_ff <= '0;
          state_ff   <= (kind_ff == serial_link_pkg::RP_DATA) ? serial_link_pkg::S_WAIT_ACK
                        : serial_link_pkg::S_IDLE;
        end
        serial_link_pkg::S_WAIT_ACK: if (ack_evt_ff) begin
          done_ok_ff <= 1'b1;
          state_ff   <= serial_link_pkg::S_IDLE;
        end else if (wait_done) begin
          dly_cnt_ff <= '0;
          if (try_ff < retries_ff) begin  // R11
            try_ff   <= try_ff + 8'h1;
            state_ff <= serial_link_pkg::S_TURN;
          end else begin
            done_err_ff <= 1'b1;  // R17
            state_ff    <= serial_link_pkg::S_IDLE;
          end
        end
      endcase
    end
  end

endmodule : half_duplex_slave_serial_link

`default_nettype wire

// ---- core/serial_byte_phy.sv ----
// Byte serialiser and deserialiser: 8 data bits, optional even parity, one stop.
// Assumes rxd is already synchronous to clk.
`default_nettype none

module serial_byte_phy #(
  parameter int unsigned BIT_W = 18
) (
  // Clock and control
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [BIT_W-1:0] bit_cycles,
  input  wire logic             par_even,
  // Transmit side
  input  wire logic             tx_start,
  input  wire logic [7:0]       tx_byte,
  output logic                  tx_busy,
  output logic                  txd,
  // Receive side
  input  wire logic             rxd,
  output logic                  rx_valid,
  output logic [7:0]            rx_byte,
  output logic                  rx_perr
);

  if (BIT_W < 4) begin : g_bad_width
    $error("BIT_W too small");
  end

  logic [BIT_W-1:0] tx_cnt_ff;
  logic [BIT_W-1:0] rx_cnt_ff;
  logic [9:0]       tx_sh_ff;
  logic [3:0]       tx_left_ff;
  logic [3:0]       rx_idx_ff;
  logic [8:0]       rx_sh_ff;
  logic             rx_act_ff;
  logic [3:0]       last_idx;

  assign last_idx = par_even ? serial_link_pkg::LAST_BIT_PAR : serial_link_pkg::LAST_BIT_NOPAR;

  // Transmit shifter, start bit leaves at once
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_busy    <= 1'b0;
      txd        <= 1'b1;
      tx_sh_ff   <= '1;
      tx_left_ff <= '0;
      tx_cnt_ff  <= '0;
    end else if (ce) begin
      if (!tx_busy) begin
        if (tx_start) begin
          tx_busy    <= 1'b1;
          txd        <= 1'b0;
          tx_sh_ff   <= {1'b1, par_even ? ^tx_byte : 1'b1, tx_byte};
          tx_left_ff <= last_idx;  // Data, parity if any, then stop
          tx_cnt_ff  <= bit_cycles - 1'b1;
        end
      end else if (tx_cnt_ff != '0) begin
        tx_cnt_ff <= tx_cnt_ff - 1'b1;
      end else if (tx_left_ff == '0) begin
        tx_busy <= 1'b0;
      end else begin
        txd        <= tx_sh_ff[0];
        tx_sh_ff   <= {1'b1, tx_sh_ff[9:1]};
        tx_left_ff <= tx_left_ff - 4'h1;
        tx_cnt_ff  <= bit_cycles - 1'b1;
      end
    end
  end

  // Receive sampler at mid-bit, false starts dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_act_ff <= 1'b0;
      rx_idx_ff <= '0;
      rx_cnt_ff <= '0;
      rx_sh_ff  <= '0;
      rx_valid  <= 1'b0;
      rx_byte   <= '0;
      rx_perr   <= 1'b0;
    end else if (ce) begin
      rx_valid <= 1'b0;
      if (!rx_act_ff) begin
        if (!rxd) begin
          rx_act_ff <= 1'b1;
          rx_idx_ff <= '0;
          rx_cnt_ff <= bit_cycles >> 1;
        end
      end else if (rx_cnt_ff != '0) begin
        rx_cnt_ff <= rx_cnt_ff - 1'b1;
      end else begin
        rx_cnt_ff <= bit_cycles - 1'b1;
        rx_idx_ff <= rx_idx_ff + 4'h1;
        if (rx_idx_ff == '0) begin
          if (rxd) rx_act_ff <= 1'b0;
        end else if (rx_idx_ff == last_idx) begin
          rx_act_ff <= 1'b0;
          rx_valid  <= 1'b1;
          rx_byte   <= par_even ? rx_sh_ff[7:0] : rx_sh_ff[8:1];
          rx_perr   <= !rxd | (par_even & ^rx_sh_ff);
        end else begin
          rx_sh_ff <= {rxd, rx_sh_ff[8:1]};
        end
      end
    end
  end

endmodule : serial_byte_phy

`default_nettype wire

// ---- core/serial_link_pkg.sv ----
// Shared constants, register map and types of the half-duplex slave serial link.
// Assumes a 40 MHz clock; everything else is sized from here.
`default_nettype none

package serial_link_pkg;

  // Clock and time bases
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned TICK_MS       = 1;
  localparam int unsigned MS_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned SLOW_TICK_MS  = 20;
  localparam int unsigned ACK_TO_SLOW   = 50;   // Acknowledge wait, 20 ms units

  // Bit rates, selected by the baud field
  localparam int unsigned BAUD_TBL [8] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400};
  localparam int unsigned BIT_W        = 18;

  // Frame shape: index of the stop bit sample
  localparam logic [3:0] LAST_BIT_PAR   = 4'hA;
  localparam logic [3:0] LAST_BIT_NOPAR = 4'h9;

  // Link codes
  localparam logic [7:0] CODE_DATA = 8'h02;
  localparam logic [7:0] CODE_EOT  = 8'h04;
  localparam logic [7:0] CODE_POLL = 8'h05;
  localparam logic [7:0] CODE_ACK  = 8'h06;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_POLL_TO  = 8'h04;
  localparam logic [7:0] OFF_RTS_OFF  = 8'h08;
  localparam logic [7:0] OFF_RTS_SEND = 8'h0C;
  localparam logic [7:0] OFF_RETRIES  = 8'h10;
  localparam logic [7:0] OFF_PRE_TX   = 8'h14;
  localparam logic [7:0] OFF_TX_QUEUE = 8'h18;
  localparam logic [7:0] OFF_RX_DATA  = 8'h1C;
  localparam logic [7:0] OFF_STATUS   = 8'h20;
  localparam logic [7:0] OFF_MASK     = 8'h24;
  localparam logic [7:0] OFF_STATE    = 8'h28;

  // Control field positions and reset values
  localparam int unsigned CTRL_BAUD_LSB = 0;
  localparam int unsigned CTRL_PAR_BIT  = 3;
  localparam int unsigned CTRL_MODE_LSB = 4;
  localparam int unsigned CTRL_EOT_BIT  = 6;
  localparam int unsigned CTRL_DUP_BIT  = 7;
  localparam logic [7:0]  CTRL_RST      = 8'h86;
  localparam logic [7:0]  RETRY_RST     = 8'h03;

  // Status bit positions
  localparam int unsigned ST_RX_PKT = 0;
  localparam int unsigned ST_TX_ACK = 1;
  localparam int unsigned ST_POLL   = 2;
  localparam int unsigned ST_RETRY  = 3;
  localparam int unsigned ST_DUP    = 4;
  localparam int unsigned ST_PERR   = 5;
  localparam int unsigned ST_W      = 6;

  typedef enum logic [1:0] {LINE_PLAIN, LINE_MODEM, LINE_RS485} line_mode_t;

  // Control register image, MSB first
  typedef struct packed {
    logic       dup_en;
    logic       eot_sup;
    line_mode_t mode;
    logic       par_even;
    logic [2:0] baud;
  } cfg_t;

  typedef enum logic [1:0] {RP_EOT, RP_ACK, RP_DATA} reply_t;

  typedef enum logic [2:0] {
    S_IDLE, S_TURN, S_RTS_LEAD, S_CTS, S_SEND, S_RTS_HOLD, S_WAIT_ACK
  } link_state_t;

  function automatic logic [BIT_W-1:0] baud_div(input logic [2:0] sel);
    return BIT_W'(CLK_HZ / BAUD_TBL[sel]);
  endfunction : baud_div

endpackage : serial_link_pkg

`default_nettype wire

// ---- dv/master_station.sv ----
// Polling master model: sends bytes on rxd, collects slave bytes from txd.
// Assumes 38400 baud, no parity, and a modem echoing RTS as CTS.
`default_nettype none
module master_station (
  // Clock
  input  wire logic clk,
  // Line to and from the slave
  input  wire logic txd,
  input  wire logic rts,
  output logic      rxd,
  output logic      cts
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = serial_link_pkg::CLK_HZ / serial_link_pkg::BAUD_TBL[7];
  logic [7:0] rx_q[$];
  logic [7:0] b;
  initial rxd = 1'b1;
  initial cts = 1'b0;
  // Modem answers RTS one cycle later
  always @(posedge clk) cts <= rts;
  // Sample slave bytes mid-bit, LSB first
  always begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      b[i] = txd;
    end
    rx_q.push_back(b);
  end
  // One master byte, start and stop framed
  task automatic send_byte(input logic [7:0] v);
    logic [9:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT) @(posedge clk);
    end
  endtask : send_byte
endmodule : master_station
`default_nettype wire

// ---- dv/serial_link_sva.sv ----
// Checker on the serial link top ports.
// Assumes one clock domain and a bind onto every link instance.
`default_nettype none
module link_checker (
  // Clock and bus
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // Line and interrupt
  input wire logic        rxd,
  input wire logic        txd,
  input wire logic        rts,
  input wire logic        drv_en,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Bus timing, line framing and modem handshake
  a_ready_answer: assert property (psel && !penable && ce |=> pready) else $error("no pready");
  a_read_hold: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("prdata moved");
  a_reset_idle: assert property ($fell(rst) |-> txd && !rts && !irq) else $error("not idle");
  a_start_bit: assert property ($fell(txd) |-> !txd [*8]) else $error("short start bit");
  a_rts_lead: assert property ($rose(rts) |-> txd [*8]) else $error("sent with rts");
  a_rts_tail: assert property ($fell(rts) |-> $past(txd, 8)) else $error("rts dropped early");
  a_rts_turn: assert property ($rose(rts) |-> $past(rxd)) else $error("rts during rx");
  a_drv_quiet: assert property (rts |-> !drv_en) else $error("driver in modem mode");
endmodule : link_checker
bind half_duplex_slave_serial_link link_checker u_link_checker (.clk, .rst, .ce, .psel,
  .penable, .prdata, .pready, .rxd, .txd, .rts, .drv_en, .irq);
`default_nettype wire

// ---- dv/tb_top.sv ----
// Bench for the serial link: APB tasks and a polling master.
// Assumes a 20-cycle millisecond tick and 38400 baud.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, rxd, txd, rts, cts, drv_en, irq, e;
  int          n_fail = 0, checks_done = 0;
  // Clock
  always #12.5 clk = ~clk;
  // Block and far side
  half_duplex_slave_serial_link #(.MS_CYCLES(20)) u_half_duplex_slave_serial_link (.clk, .rst,
    .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd,
    .txd, .rts, .cts, .drv_en, .irq);
  master_station u_master_station (.clk, .txd, .rts, .rxd, .cts);
  task automatic chk(input string nm, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic close_out;
    if (n_fail == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task automatic s_regs;
    apb(1'b0, serial_link_pkg::OFF_CTRL, 32'h0);
    chk("ctrl", 32'h86, q);
    apb(1'b0, serial_link_pkg::OFF_RETRIES, 32'h0);
    chk("retries", 32'h3, q);
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped", 32'h1, 32'(e));
  endtask : s_regs
  task automatic s_eot;
    apb(1'b1, serial_link_pkg::OFF_CTRL, 32'hC7);
    u_master_station.send_byte(serial_link_pkg::CODE_POLL);
    repeat (10000) @(posedge clk);
    chk("silent", 32'h0, 32'(u_master_station.rx_q.size()));
  endtask : s_eot
  task automatic s_modem;
    apb(1'b1, serial_link_pkg::OFF_CTRL, 32'h97);
    apb(1'b1, serial_link_pkg::OFF_POLL_TO, 32'h64);
    apb(1'b1, serial_link_pkg::OFF_RTS_SEND, 32'h1);
    apb(1'b1, serial_link_pkg::OFF_RTS_OFF, 32'h1);
    apb(1'b1, serial_link_pkg::OFF_MASK, 32'h2);
    apb(1'b1, serial_link_pkg::OFF_TX_QUEUE, 32'hA5);
    u_master_station.send_byte(serial_link_pkg::CODE_POLL);
    while (u_master_station.rx_q.size() < 3 || rts !== 1'b0) @(posedge clk);
    chk("code", 32'h2, 32'(u_master_station.rx_q[0]));
    chk("seq", 32'h1, 32'(u_master_station.rx_q[1]));
    chk("data", 32'hA5, 32'(u_master_station.rx_q[2]));
    u_master_station.send_byte(serial_link_pkg::CODE_ACK);
    repeat (8) @(posedge clk);
    chk("irq", 32'h1, 32'(irq));
    apb(1'b0, serial_link_pkg::OFF_STATUS, 32'h0);
    chk("status", 32'h2, q);
    repeat (2) @(posedge clk);
    chk("irq clear", 32'h0, 32'(irq));
  endtask : s_modem
  task automatic s_timeout;
    apb(1'b1, serial_link_pkg::OFF_POLL_TO, 32'h1);
    apb(1'b1, serial_link_pkg::OFF_TX_QUEUE, 32'h3C);
    repeat (1000) @(posedge clk);
    apb(1'b0, serial_link_pkg::OFF_STATUS, 32'h0);
    chk("poll timeout", 32'h4, q);
    apb(1'b1, serial_link_pkg::OFF_TX_QUEUE, 32'h3C);
    chk("requeue", 32'h0, 32'(e));
  endtask : s_timeout
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    s_regs();
    s_eot();
    s_modem();
    s_timeout();
    close_out();
  end
  // Watchdog
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    close_out();
  end
endmodule : tb_top
`default_nettype wire
